//--- design/sme_map.svh
// constants for the serial master engine: clock, rates, status codes
// assumes a single system clock whose rate is given by SME_CLK_HZ
`ifndef SME_MAP_SVH
`define SME_MAP_SVH

`define SME_CLK_HZ 32'd25000000

// selectable bit rates in hertz
`define SME_RATE_125K 32'd125000
`define SME_RATE_250K 32'd250000
`define SME_RATE_500K 32'd500000
`define SME_RATE_1M 32'd1000000
`define SME_RATE_2M 32'd2000000
`define SME_RATE_4M 32'd4000000
`define SME_RATE_8M 32'd8000000

// highest legal clock mode value
`define SME_MODE_MAX 32'd3

// position of the lsb-first flag in the configuration word
`define SME_CFG_LSB_FIRST 0

// status codes reported on open
`define SME_ST_OK 16'h0000
`define SME_ST_NO_DRIVER 16'h5200
`define SME_ST_ALREADY_OPEN 16'h5207
`define SME_ST_NO_RESOURCE 16'h521d
`define SME_ST_BAD_RATE 16'h5225
`define SME_ST_BAD_MODE 16'h522b

// reset values
`define SME_RST_HALF 16'd1
`define SME_RST_MOSI 1'b0

// serial clock edges per byte
`define SME_EDGES_PER_BYTE 5'd16

`endif

//--- design/sme_pkg.sv
// types shared by the serial master engine
// assumes sme_map.svh is on the include path
package sme_pkg;

    // engine state
    typedef enum logic [0:0] {
        SME_IDLE,
        SME_RUN
    } sme_state_t;

    // configuration latched on a successful open
    typedef struct packed {
        logic cpol;
        logic cpha;
        logic lsb_first;
        logic [15:0] half_cnt;
    } sme_cfg_t;

endpackage

//--- design/sme_spi_master.sv
// serial peripheral master engine: open/close, byte-wide duplex exchange
// assumes a host pulses requests on clk_i and selects the slave itself
//
// Summary of operation
// - engine is master only and always makes the serial clock itself.
// - sck and mosi are driven outputs; miso is a sampled input.
// - clock mode 0..3 sets polarity (bit 1) and phase (bit 0).
// - bit rate accepted only from the seven listed rates, 125 kHz-8 MHz.
// - config bit 0 set shifts lsb first both ways, else msb first.
// - each 8 clock pulses send one byte and capture one byte.
// - every byte sent returns exactly one received byte.
// - open reports 0, bad rate 5225, bad mode 522b, already open 5207.
// - open reports 521d for busy resource, 5200 for absent driver.
// - close is accepted harmlessly even when already closed.
// - exchange finishes before another request; no async events.
`timescale 1ns/1ns
`include "sme_map.svh"

module sme_spi_master
    import sme_pkg::*;
#(
    parameter int unsigned CLK_HZ = 25000000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic open_request_i,
    input wire logic [31:0] clock_mode_select_i,
    input wire logic [31:0] bit_rate_select_i,
    input wire logic [31:0] config_flag_word_i,
    input wire logic driver_absent_i,
    input wire logic resource_busy_i,
    input wire logic close_request_i,
    input wire logic duplex_exchange_request_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic miso_i,
    output logic sck_o,
    output logic mosi_o,
    output logic [15:0] status_o,
    output logic status_valid_o,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o,
    output logic busy_o,
    output logic open_o
);

    // true when the requested rate is one of the supported set
    function automatic logic rate_ok(input logic [31:0] hz);
        rate_ok = (hz == `SME_RATE_125K) || (hz == `SME_RATE_250K) ||
                  (hz == `SME_RATE_500K) || (hz == `SME_RATE_1M) ||
                  (hz == `SME_RATE_2M) || (hz == `SME_RATE_4M) ||
                  (hz == `SME_RATE_8M);
    endfunction

    // clocks per half bit; rounds down, never below one, so 8 MHz
    // actually runs at clk/2 when the system clock is only 25 MHz
    function automatic logic [15:0] half_of(input logic [31:0] hz);
        logic [31:0] q;
        q = 32'(CLK_HZ) / (hz << 1);
        if (q == 32'd0) begin
            q = 32'd1;
        end
        half_of = q[15:0];
    endfunction

    // pick one data bit by serial position and bit order
    function automatic logic pick_bit(input logic [7:0] b,
                                      input logic [2:0] idx,
                                      input logic lsb);
        pick_bit = lsb ? b[idx] : b[3'd7 - idx];
    endfunction

    // shift one captured bit into the receive byte
    function automatic logic [7:0] shift_in(input logic [7:0] b,
                                            input logic bit_in,
                                            input logic lsb);
        shift_in = lsb ? {bit_in, b[7:1]} : {b[6:0], bit_in};
    endfunction

    sme_state_t state_q;
    sme_cfg_t cfg_q;
    logic open_q;
    logic close_pend_q;
    logic [15:0] div_q;
    logic [4:0] edge_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic miso_m_q;
    logic miso_s_q;
    logic sck_q;
    logic mosi_q;
    logic [15:0] status_q;
    logic status_valid_q;
    logic [7:0] rx_byte_q;
    logic rx_valid_q;

    logic take_xfer;
    logic tick;
    logic leading;
    logic do_sample;
    logic do_shift;
    logic last_edge;
    logic [2:0] shift_idx;
    logic [7:0] rx_next;
    logic [15:0] open_code;

    // miso crosses from the slave's timing domain; two flops first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
        end else if (ce_i) begin
            miso_m_q <= miso_i;
            miso_s_q <= miso_m_q;
        end
    end

    // open outcome in priority order: driver, already open, mode, rate,
    // resource
    always_comb begin
        if (driver_absent_i) begin
            open_code = `SME_ST_NO_DRIVER;
        end else if (open_q) begin
            open_code = `SME_ST_ALREADY_OPEN;
        end else if (clock_mode_select_i > `SME_MODE_MAX) begin
            open_code = `SME_ST_BAD_MODE;
        end else if (!rate_ok(bit_rate_select_i)) begin
            open_code = `SME_ST_BAD_RATE;
        end else if (resource_busy_i) begin
            open_code = `SME_ST_NO_RESOURCE;
        end else begin
            open_code = `SME_ST_OK;
        end
    end

    // exchange is only taken while open and idle; a close in the same
    // cycle wins so no byte can run on a closed engine
    assign take_xfer = duplex_exchange_request_i && open_q &&
                       (state_q == SME_IDLE) && !close_pend_q &&
                       !close_request_i;

    // edge bookkeeping: edge_q counts edges already made in this byte
    assign tick = (state_q == SME_RUN) && (div_q == 16'd1);
    assign leading = !edge_q[0];
    assign do_sample = tick && (leading ^ cfg_q.cpha);
    assign last_edge = (edge_q == (`SME_EDGES_PER_BYTE - 5'd1));
    // phase 0 moves data on trailing edges, phase 1 on leading ones
    assign do_shift = tick && !do_sample && !(last_edge && !cfg_q.cpha);
    assign shift_idx = cfg_q.cpha ? edge_q[3:1] : 3'(edge_q[3:1] + 3'd1);
    assign rx_next = do_sample ? shift_in(rx_q, miso_s_q, cfg_q.lsb_first)
                               : rx_q;

    // open, close and configuration latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            open_q <= 1'b0;
            close_pend_q <= 1'b0;
            cfg_q <= '{cpol: 1'b0, cpha: 1'b0, lsb_first: 1'b0,
                       half_cnt: `SME_RST_HALF};
        end else if (ce_i) begin
            if (open_request_i) begin
                if (open_code == `SME_ST_OK) begin
                    open_q <= 1'b1;
                    cfg_q.cpol <= clock_mode_select_i[1];
                    cfg_q.cpha <= clock_mode_select_i[0];
                    // only bit 0 is looked at; the rest must be zero
                    cfg_q.lsb_first <=
                        config_flag_word_i[`SME_CFG_LSB_FIRST];
                    cfg_q.half_cnt <= half_of(bit_rate_select_i);
                end
            end else if (close_request_i || close_pend_q) begin
                // a close during a byte waits for the byte to end
                if (state_q == SME_RUN) begin
                    close_pend_q <= 1'b1;
                end else begin
                    open_q <= 1'b0;
                    close_pend_q <= 1'b0;
                end
            end
        end
    end

    // status answer: one pulse per open or close request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= `SME_ST_OK;
            status_valid_q <= 1'b0;
        end else if (ce_i) begin
            status_valid_q <= 1'b0;
            if (open_request_i) begin
                status_q <= open_code;
                status_valid_q <= 1'b1;
            end else if (close_request_i) begin
                status_q <= `SME_ST_OK; // closing never fails
                status_valid_q <= 1'b1;
            end
        end
    end

    // byte sequencer: 16 clock edges per byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= SME_IDLE;
            div_q <= `SME_RST_HALF;
            edge_q <= 5'd0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
        end else if (ce_i) begin
            case (state_q)
                SME_IDLE: begin
                    if (take_xfer) begin
                        state_q <= SME_RUN;
                        div_q <= cfg_q.half_cnt;
                        edge_q <= 5'd0;
                        tx_q <= tx_byte_i;
                        rx_q <= 8'h00;
                    end
                end
                SME_RUN: begin
                    if (tick) begin
                        div_q <= cfg_q.half_cnt;
                        edge_q <= edge_q + 5'd1;
                        rx_q <= rx_next;
                        if (last_edge) begin
                            state_q <= SME_IDLE;
                        end
                    end else begin
                        div_q <= div_q - 16'd1;
                    end
                end
                default: begin
                    state_q <= SME_IDLE;
                end
            endcase
        end
    end

    // serial clock: rests at polarity level, toggles per half bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_q <= 1'b0;
        end else if (ce_i) begin
            if (state_q == SME_IDLE) begin
                sck_q <= cfg_q.cpol;
            end else if (tick) begin
                sck_q <= !sck_q;
            end
        end
    end

    // mosi: first bit set up at start for phase 0, held between bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mosi_q <= `SME_RST_MOSI;
        end else if (ce_i) begin
            if (take_xfer && !cfg_q.cpha) begin
                mosi_q <= pick_bit(tx_byte_i, 3'd0, cfg_q.lsb_first);
            end else if (do_shift) begin
                mosi_q <= pick_bit(tx_q, shift_idx, cfg_q.lsb_first);
            end
        end
    end

    // one received byte per byte sent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_byte_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end else if (ce_i) begin
            rx_valid_q <= 1'b0;
            if (tick && last_edge) begin
                rx_byte_q <= rx_next;
                rx_valid_q <= 1'b1;
            end
        end
    end

    // busy is a flop so the host sees a registered handshake; it drops
    // in the same cycle rx_valid rises
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else if (ce_i) begin
            if (take_xfer) begin
                busy_o <= 1'b1;
            end else if (tick && last_edge) begin
                busy_o <= 1'b0;
            end
        end
    end

    assign sck_o = sck_q;
    assign mosi_o = mosi_q;
    assign status_o = status_q;
    assign status_valid_o = status_valid_q;
    assign rx_byte_o = rx_byte_q;
    assign rx_valid_o = rx_valid_q;
    assign open_o = open_q;

endmodule

//--- test/sme_slave_model.sv
// behavioural slave on the far side of the serial link
// assumes the bench drives its select low around each exchange
`timescale 1ns/1ns
module sme_slave_model (
    input wire logic sel_n_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic lsb_i,
    input wire logic [7:0] tx_i,
    output logic miso_o,
    output logic [7:0] rx_o
);
    int k;
    initial miso_o = 1'b0;
    // next bit out; phase 0 puts the first one out at select
    task automatic put();
        if (k < 8) miso_o = lsb_i ? tx_i[k] : tx_i[7 - k];
        k++;
    endtask
    always @(negedge sel_n_i) begin
        k = 0;
        rx_o = 8'h00;
        if (!cpha_i) put();
    end
    // a released line shows the inverse so a held copy cannot pass
    always @(posedge sel_n_i) miso_o = ~miso_o;
    // sample on one edge, shift on the other, by polarity and phase
    always @(sck_i) begin
        if (!sel_n_i && sck_i == ~(cpol_i ^ cpha_i)) begin
            rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
        end else if (!sel_n_i) begin
            put();
        end
    end
endmodule

//--- test/sme_spi_master_sva.sv
// checker for the serial master engine, port view only
// assumes a bind onto sme_spi_master with one clock and sync reset
`timescale 1ns/1ns
module sme_spi_master_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic open_request_i,
    input wire logic [31:0] clock_mode_select_i,
    input wire logic driver_absent_i,
    input wire logic close_request_i,
    input wire logic duplex_exchange_request_i,
    input wire logic sck_o,
    input wire logic mosi_o,
    input wire logic [15:0] status_o,
    input wire logic status_valid_o,
    input wire logic rx_valid_o,
    input wire logic busy_o,
    input wire logic open_o
);
    logic cpol_q, sck_q, cp_q;
    logic [4:0] ec_q;
    wire logic edge_w = sck_o != sck_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // shadow of idle polarity, pending close and edges in the byte
    always_ff @(posedge clk_i) begin
        sck_q <= sck_o;
        if (open_request_i && !open_o) cpol_q <= clock_mode_select_i[1];
        if (rst_i || !open_o) cp_q <= 1'b0;
        else if (close_request_i && busy_o) cp_q <= 1'b1;
        if (rst_i || rx_valid_o) ec_q <= 5'h00;
        else if (busy_o && edge_w) ec_q <= ec_q + 5'h01;
    end
    a_open_answer: assert property (open_request_i |=> status_valid_o)
        else $error("open not answered");
    a_err_absent: assert property (open_request_i && driver_absent_i
        |=> status_o == 16'h5200 && open_o == $past(open_o))
        else $error("absent driver code wrong");
    a_err_open: assert property (open_request_i && !driver_absent_i
        && open_o |=> status_o == 16'h5207)
        else $error("already open code wrong");
    a_err_mode: assert property (open_request_i && !driver_absent_i
        && !open_o && clock_mode_select_i > 32'h3
        |=> status_o == 16'h522b && !open_o)
        else $error("bad mode code wrong");
    a_close_ok: assert property (close_request_i && !open_request_i
        |=> status_valid_o && status_o == 16'h0000)
        else $error("close answer wrong");
    a_xch_take: assert property (duplex_exchange_request_i && open_o
        && !busy_o && !cp_q && !close_request_i |=> busy_o)
        else $error("exchange not taken");
    a_byte_edges: assert property (rx_valid_o
        |-> ec_q + {4'h0, edge_w} == 5'h10)
        else $error("edge count per byte wrong");
    a_rx_end: assert property (rx_valid_o |-> !busy_o && $past(busy_o))
        else $error("byte answer without transfer");
    a_closed_quiet: assert property (!open_o && !$past(open_o)
        |-> !busy_o && !rx_valid_o)
        else $error("activity while closed");
    a_sck_idle: assert property (open_o && $past(open_o) && !busy_o
        && !$past(busy_o) |-> sck_o == cpol_q && $stable(mosi_o))
        else $error("idle lines moved");
endmodule

//--- test/testbench.sv
// self-checking bench: open, errors, close and byte exchanges
// assumes design files and the slave model are compiled first
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0, rst = 1'b1, op = 1'b0, cl = 1'b0, xr = 1'b0, ce = 1'b1;
    logic absent = 1'b0, rbusy = 1'b0, sel_n = 1'b1, lsb = 1'b0, miso;
    logic [31:0] mode = 32'h0, rate = 32'd4000000;
    logic [7:0] txb = 8'h00, stx = 8'h00, srx, rxb;
    logic sck, mosi, sv, rv, bsy, opn;
    logic [15:0] st;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    always #20 clk = ~clk;
    sme_spi_master u_sme_spi_master (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .open_request_i(op),
        .clock_mode_select_i(mode), .bit_rate_select_i(rate),
        .config_flag_word_i({31'h0, lsb}),
        .driver_absent_i(absent), .resource_busy_i(rbusy),
        .close_request_i(cl), .duplex_exchange_request_i(xr),
        .tx_byte_i(txb), .miso_i(miso), .sck_o(sck), .mosi_o(mosi),
        .status_o(st), .status_valid_o(sv), .rx_byte_o(rxb),
        .rx_valid_o(rv), .busy_o(bsy), .open_o(opn));
    sme_slave_model u_sme_slave_model (
        .sel_n_i(sel_n), .sck_i(sck), .mosi_i(mosi), .cpol_i(mode[1]),
        .cpha_i(mode[0]), .lsb_i(lsb), .tx_i(stx), .miso_o(miso),
        .rx_o(srx));
    task automatic complete_run();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic open_dev(logic [31:0] m, logic [31:0] r, logic [15:0] e);
        mode = m;
        rate = r;
        op = 1'b1;
        tick();
        // the answer pulse stands for one cycle only
        chk("status valid", sv, 1);
        chk("status", st, e);
        op = 1'b0;
        tick();
        chk("status pulse", sv, 0);
    endtask
    task automatic close_dev();
        cl = 1'b1;
        tick();
        chk("close valid", sv, 1);
        chk("close status", st, 0);
        cl = 1'b0;
        tick();
        chk("closed", opn, 0);
    endtask
    // select is held by the host around the whole byte; fz cycles of
    // low enable right after the request must only stretch the byte
    task automatic xch(logic [7:0] t, logic [7:0] s, int fz = 0);
        int n;
        stx = s;
        sel_n = 1'b0;
        txb = t;
        xr = 1'b1;
        tick();
        xr = 1'b0;
        if (fz > 0) begin
            ce = 1'b0;
            repeat (fz) tick();
            ce = 1'b1;
            chk("busy frozen", bsy, 1);
        end
        for (n = 0; n < 2000 && rv !== 1'b1; n++) tick();
        chk("latency", n, 16 * (25000000 / (2 * rate)));
        chk("rx byte", rxb, s);
        chk("slave rx", srx, t);
        sel_n = 1'b1;
        // select stays released for a cycle between bytes
        tick();
    endtask
    // reset while open returns open, sck, status and busy to their rest values
    task automatic t_reset();
        open_dev(3, 32'd2000000, 16'h0000);
        open_dev(3, 32'd2000000, 16'h5207);
        rst = 1'b1;
        tick();
        rst = 1'b0;
        chk("reset open", opn, 0);
        chk("reset sck", sck, 0);
        chk("reset status", st, 0);
        chk("reset busy", bsy, 0);
    endtask
    task automatic t_errors();
        xr = 1'b1;
        tick();
        xr = 1'b0;
        tick();
        chk("busy closed", bsy, 0);
        absent = 1'b1;
        open_dev(0, 32'd4000000, 16'h5200);
        absent = 1'b0;
        rbusy = 1'b1;
        open_dev(0, 32'd4000000, 16'h521d);
        rbusy = 1'b0;
        open_dev(4, 32'd4000000, 16'h522b);
        open_dev(0, 32'd3000000, 16'h5225);
        open_dev(0, 32'd125001, 16'h5225);
        chk("open", opn, 0);
    endtask
    task automatic t_rates();
        int rt [7] = '{125000, 250000, 500000, 1000000, 2000000,
            4000000, 8000000};
        foreach (rt[i]) begin
            open_dev(i % 4, rt[i], 16'h0000);
            chk("open", opn, 1);
            open_dev(0, 32'd4000000, 16'h5207);
            close_dev();
        end
        close_dev();
        chk("open", opn, 0);
    endtask
    // every mode, both bit orders, back to back bytes
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            lsb = m[0];
            open_dev(m, 32'd4000000, 16'h0000);
            xch(8'h1d + m[7:0], 8'hd0 - m[7:0]);
            xch(8'h01, 8'h80, 5 * m);
            close_dev();
        end
        lsb = 1'b0;
        open_dev(0, 32'd125000, 16'h0000);
        xch(8'h96, 8'h4b);
        close_dev();
    endtask
    // hang guard well above the expected few thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        t_errors();
        t_rates();
        t_reset();
        t_modes();
        complete_run();
    end
endmodule
bind sme_spi_master sme_spi_master_sva u_sme_spi_master_sva (
    .clk_i(clk_i), .rst_i(rst_i), .open_request_i(open_request_i),
    .clock_mode_select_i(clock_mode_select_i),
    .driver_absent_i(driver_absent_i), .close_request_i(close_request_i),
    .duplex_exchange_request_i(duplex_exchange_request_i),
    .sck_o(sck_o), .mosi_o(mosi_o), .status_o(status_o),
    .status_valid_o(status_valid_o), .rx_valid_o(rx_valid_o),
    .busy_o(busy_o), .open_o(open_o));
